// ### smc_card_model.sv
`timescale 1ns/1ps
`default_nettype none
// two cards: a speaker tone and a slow writer draining socket a
module smc_card_model (
    input  wire logic       i_clk,
    input  wire logic       i_drain,     // card accepts writes
    input  wire logic [1:0] i_fifo_push,
    output logic      [1:0] o_fifo_pop,
    output logic      [1:0] o_card_speaker_input
);
    logic [3:0] held = 4'h0;   // entries still owed to the card
    logic [2:0] tone = 3'h0;   // free running divider
    always @(posedge i_clk) begin
        tone <= tone + 3'h1;
        held <= held + 4'(i_fifo_push[0]) - 4'(o_fifo_pop[0]);
    end
    // one pop every eighth cycle, never more than was pushed
    assign o_fifo_pop = {1'b0, i_drain && held != 4'h0 && tone == 3'h0};
    assign o_card_speaker_input = tone[2:1];
endmodule : smc_card_model
`default_nettype wire

// ### smc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks against shadow copies of the registers
module smc_chk
    import smc_pkg::*;
#(
    parameter int NSOCK = 2
)(
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire logic             i_wr,
    input wire logic             i_sock,
    input wire logic [7:0]       i_idx,
    input wire logic [7:0]       i_wdata,
    input wire logic [NSOCK-1:0] i_power_on,
    input wire logic [NSOCK-1:0] i_card_in,
    input wire logic [NSOCK-1:0] i_card_speaker_input,
    input wire logic             i_card_status_change_input,
    input wire logic             i_pci_busy,
    input wire logic [NSOCK-1:0] o_vcc3_en_n,
    input wire logic [NSOCK-1:0] o_fifo_empty,
    input wire logic             o_speaker_output,
    input wire logic             o_speaker_output_oe,
    input wire logic             o_interrupt15_ring_out_pin,
    input wire logic             o_use_ext_clk,
    input wire logic             o_clk_gate_en,
    input wire logic             o_socket_refuse,
    input wire logic             o_ttl_thresh,
    input wire logic             o_timer_tick
);
    logic [7:0] m1a, m1b, m2;   // shadows; socket a, socket b, chip
    wire wr1 = i_wr && i_idx == IDX_MISC_ONE;
    // shadows follow host writes, so outputs are judged one edge later
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            m1a <= M1_RESET;
            m1b <= M1_RESET;
            m2 <= M2_RESET;
        end else begin
            if (wr1 && !i_sock) m1a <= i_wdata & M1_WRITE_MSK;
            if (wr1 && i_sock) m1b <= i_wdata & M1_WRITE_MSK;
            if (i_wr && i_idx == IDX_MISC_TWO) m2 <= i_wdata;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // any of the three causes empties socket a
    sequence s_flush;
        (wr1 == 0 && i_wr && i_idx == IDX_FIFO_CTRL && !i_sock && i_wdata[FC_STATUS])
        || !i_card_in[0] || !i_power_on[0];
    endsequence
    sequence s_fall;
        m2[M2_RING_OUT] && i_card_status_change_input ##1 m2[M2_RING_OUT] && !i_card_status_change_input;
    endsequence
    property p_vcc; o_vcc3_en_n[0] == !$past(i_power_on[0] && m1a[M1_SUPPLY_SEL]); endproperty
    a_vcc: assert property (p_vcc) else $error("supply enable wrong");
    property p_spk; o_speaker_output_oe |-> o_speaker_output == $past(^(i_card_speaker_input & {m1b[4], m1a[4]}));
    endproperty
    a_spk: assert property (p_spk) else $error("speaker mix wrong");
    property p_flush; s_flush |-> ##[1:2] o_fifo_empty[0]; endproperty
    a_flush: assert property (p_flush) else $error("fifo not emptied");
    property p_ext; o_use_ext_clk == $past(m2[M2_EXT_CLK] && !i_pci_busy); endproperty
    a_ext: assert property (p_ext) else $error("clock source wrong");
    property p_run; $past(!m2[M2_LOW_POWER] && !m2[M2_SUSPEND]) |-> o_clk_gate_en; endproperty
    a_run: assert property (p_run) else $error("clock stopped");
    property p_susp; $past(m2[M2_SUSPEND]) |-> o_socket_refuse && !o_clk_gate_en; endproperty
    a_susp: assert property (p_susp) else $error("suspend ignored");
    property p_ttl; o_ttl_thresh == $past(m2[M2_CORE_5V]); endproperty
    a_ttl: assert property (p_ttl) else $error("threshold wrong");
    property p_div; $past(m2[M2_TMR_DIV]) && $past(m2[M2_TMR_DIV], 2) |-> o_timer_tick != $past(o_timer_tick);
    endproperty
    a_div: assert property (p_div) else $error("tick not halved");
    property p_ring; s_fall |=> !o_interrupt15_ring_out_pin; endproperty
    a_ring: assert property (p_ring) else $error("no ring pulse");
endmodule : smc_chk
`default_nettype wire

// ### smc_pkg.sv
package smc_pkg;
    // register indexes, 8-bit index space
    localparam logic [7:0] IDX_MISC_ONE  = 8'h16;
    localparam logic [7:0] IDX_FIFO_CTRL = 8'h17;
    localparam logic [7:0] IDX_MISC_TWO  = 8'h1e;
    // misc one fields
    localparam int M1_SUPPLY_SEL  = 1;
    localparam int M1_PULSE_MGMT  = 2;
    localparam int M1_PULSE_SYS   = 3;
    localparam int M1_SPK_EN      = 4;
    localparam int M1_INPACK_EN   = 7;
    localparam logic [7:0] M1_RESET     = 8'h00;
    localparam logic [7:0] M1_WRITE_MSK = 8'hfe;   // bit 0 reserved, reads zero
    // fifo control fields
    localparam int FC_STATUS      = 7;
    localparam logic [6:0] FC_SCRATCH_RESET = 7'h00;
    // misc two fields
    localparam int M2_EXT_CLK     = 0;
    localparam int M2_LOW_POWER   = 1;
    localparam int M2_SUSPEND     = 2;
    localparam int M2_CORE_5V     = 3;
    localparam int M2_TMR_DIV     = 4;
    localparam int M2_RING_OUT    = 7;
    localparam logic [7:0] M2_RESET     = 8'h02;
    // pulse train timing
    localparam int PULSE_NS       = 100;
    localparam int CLK_NS         = 25;
    localparam int PULSE_CYC      = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] PULSE_LEN = 4'(PULSE_CYC);
endpackage : smc_pkg

// ### smc_pulse.sv
`timescale 1ns/1ps
`default_nettype none
// turns an interrupt level into a level or a repeating low pulse
module smc_pulse
    import smc_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_req,       // interrupt request level
    input  wire logic i_pulse,     // pulse mode select
    input  wire logic i_clk_ok,    // some clock is running
    output logic      o_drive,     // value to put on pin
    output logic      o_oe         // pin enable
);
    typedef struct packed {
        logic [3:0] cnt;           // phase counter
        logic       drive;
        logic       oe;
    } smc_pst_t;

    smc_pst_t st;
    smc_pst_t next_st;

    // level mode drives request; pulse mode drives low then releases
    always_comb begin
        next_st = st;
        if (!i_pulse) begin
            next_st.cnt   = 4'h0;
            next_st.drive = i_req;
            next_st.oe    = 1'b1;
        end else if (i_req && i_clk_ok) begin // pulses need a live clock
            next_st.cnt   = (st.cnt == PULSE_LEN) ? 4'h0 : st.cnt + 4'h1;
            next_st.drive = 1'b0;
            next_st.oe    = (st.cnt < PULSE_LEN / 4'h2);
        end else begin
            next_st.cnt   = 4'h0;
            next_st.drive = 1'b0;
            next_st.oe    = 1'b0;          // released so the line can be shared
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_drive = st.drive;
    assign o_oe    = st.oe;
endmodule : smc_pulse
`default_nettype wire

// ### smc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - supply select picks 5 V or 3.3 V enable
// - management interrupt level or pulse mode
// - system interrupt level or pulse mode
// - pulses need a running clock
// - speaker output is xor of enabled sockets
// - input acknowledge gated by enable bit
// - fifo status reads one when empty
// - writing one flushes the write fifo
// - reset, removal, power off flush fifo
// - external clock used when pci idle
// - low power mode gates clock when idle
// - suspend stops clock, refuses socket access
// - core voltage bit selects input thresholds
// - ring indicate on status change fall
module smc_regs
    import smc_pkg::*;
#(
    parameter int NSOCK = 2                        // sockets
)(
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // indexed register port
    // one strobe per cycle; read data is
    // registered and follows one cycle later
    input  wire logic             i_wr,            // write strobe
    input  wire logic             i_rd,            // read strobe
    input  wire logic             i_sock,          // socket selected by index
    input  wire logic [7:0]       i_idx,           // register index
    input  wire logic [7:0]       i_wdata,
    output logic      [7:0]       o_rdata,         // registered read data
    // socket side
    // all pin inputs are taken as already
    // synchronous to i_clk
    input  wire logic [NSOCK-1:0] i_power_on,      // card power applied
    input  wire logic [NSOCK-1:0] i_card_in,       // card present
    input  wire logic [NSOCK-1:0] i_fifo_push,     // write fifo entry taken
    input  wire logic [NSOCK-1:0] i_fifo_pop,      // write fifo entry drained
    input  wire logic [NSOCK-1:0] i_card_speaker_input,
    input  wire logic [NSOCK-1:0] i_inpack_n,
    input  wire logic [NSOCK-1:0] i_mgmt_irq,
    input  wire logic [NSOCK-1:0] i_sys_irq,
    input  wire logic             i_card_status_change_input,
    input  wire logic             i_irq15,
    input  wire logic             i_pci_busy,      // pci transfer under way
    input  wire logic             i_pci_clk_ok,
    input  wire logic             i_interrupt14_external_clock_pin,
    input  wire logic             i_core_busy,     // internal work pending
    // supply enables are active low; the
    // other outputs are active high, except the ring output and pulse-mode pins, which go low
    output logic      [NSOCK-1:0] o_vcc5_en_n,
    output logic      [NSOCK-1:0] o_vcc3_en_n,
    output logic      [NSOCK-1:0] o_fifo_empty,
    output logic      [NSOCK-1:0] o_inpack_drv,    // use inpack for bus drivers
    output logic      [NSOCK-1:0] o_mgmt_pin,
    output logic      [NSOCK-1:0] o_mgmt_pin_oe,
    output logic      [NSOCK-1:0] o_system_interrupt_pins,
    output logic      [NSOCK-1:0] o_system_interrupt_pins_oe,
    output logic                  o_speaker_output,
    output logic                  o_speaker_output_oe,
    output logic                  o_interrupt15_ring_out_pin,
    output logic                  o_use_ext_clk,
    output logic                  o_clk_gate_en,   // high lets the internal clock run
    output logic                  o_socket_refuse,
    output logic                  o_ttl_thresh,
    output logic                  o_timer_tick     // socket timing clock enable
);
    // 16h and 17h: one copy per socket,
    // picked by i_sock
    // 1eh: one chip-wide copy, i_sock unused
    // other indexes read zero, writes dropped
    // the fifo lives in the socket datapath;
    // here only its fill level is mirrored
    // from the push and pop pulses
    // four bits cover the datapath depth;
    // the level saturates, it never wraps
    // an overflow would be a datapath bug
    // that this mirror does not report
    localparam int CW = 4;                         // fifo count width

    // every flop outside the interrupt shapers is in this struct;
    // comb logic builds next_st, one always_ff
    // copies it, outputs are views of fields
    typedef struct packed {
        logic [NSOCK-1:0][7:0]    m1;              // per socket misc one
        logic [NSOCK-1:0][6:0]    fsc;             // fifo scratch bits
        logic [NSOCK-1:0][CW-1:0] fcnt;            // write fifo fill level
        logic [7:0]               m2;              // chip-wide misc two
        logic [7:0]               rdata;
        logic [NSOCK-1:0]         v5;
        logic [NSOCK-1:0]         v3;
        logic [NSOCK-1:0]         empty;
        logic [NSOCK-1:0]         inpk;
        logic                     spk;
        logic                     spk_oe;
        logic                     sc_q;            // previous status change
        logic                     ri;
        logic                     extc;
        logic                     gate;
        logic                     refuse;
        logic                     ttl;
        logic                     tdiv;            // divide phase
        logic                     tick;
    } smc_st_t;

    // registered state and its next value
    smc_st_t st;
    smc_st_t next_st;
    logic    clk_ok;

    // shared index decode for all write ports
    // true when en is set and idx matches register want
    function automatic logic hit(input logic en, input logic [7:0] idx,
                                 input logic [7:0] want);
        hit = en && (idx == want);
    endfunction : hit

    // pulses are timed from the internal
    // clock, so they need pci clock or the
    // external clock; the pin counts only once
    // enabled as a clock, else it is irq 14
    // with no clock, shapers in pulse mode release pins
    assign clk_ok = i_pci_clk_ok || (st.m2[M2_EXT_CLK] && i_interrupt14_external_clock_pin);

    // per socket interrupt pin shaping
    // two shapers per socket, each with its
    // own level or pulse select bit; they keep
    // their own flops, so pins leave a register
    for (genvar s = 0; s < NSOCK; s++) begin : g_irq
        smc_pulse u_mgmt (
            .i_clk    (i_clk),
            .i_rst_n  (i_rst_n),
            .i_req    (i_mgmt_irq[s]),
            .i_pulse  (st.m1[s][M1_PULSE_MGMT]),
            .i_clk_ok (clk_ok),
            .o_drive  (o_mgmt_pin[s]),
            .o_oe     (o_mgmt_pin_oe[s])
        );
        smc_pulse u_sys (
            .i_clk    (i_clk),
            .i_rst_n  (i_rst_n),
            .i_req    (i_sys_irq[s]),
            .i_pulse  (st.m1[s][M1_PULSE_SYS]),
            .i_clk_ok (clk_ok),
            .o_drive  (o_system_interrupt_pins[s]),
            .o_oe     (o_system_interrupt_pins_oe[s])
        );
    end

    // register file and derived outputs
    // one pass over the sockets: writes, fifo
    // mirror, pin functions; chip fields after
    // flush and push resolve in one place
    // a write is readable the cycle after it
    always_comb begin
        logic spk_x;
        logic any_busy;
        spk_x    = 1'b0;
        any_busy = 1'b0;
        next_st  = st;
        // sockets are independent; only the
        // speaker mix and the busy flag gather
        // results across them
        for (int s = 0; s < NSOCK; s++) begin
            // writes go to the socket named by the index; one chip copy of m2
            if (hit(i_wr && (i_sock == 1'(s)), i_idx, IDX_MISC_ONE)) begin
                next_st.m1[s] = i_wdata & M1_WRITE_MSK;
            end
            if (hit(i_wr && (i_sock == 1'(s)), i_idx, IDX_FIFO_CTRL)) begin
                next_st.fsc[s] = i_wdata[6:0];
            end
            // fifo level follows push and pop
            // push with pop cancels, so the level
            // stays exact at full streaming rate
            if (i_fifo_push[s] && !i_fifo_pop[s] && st.fcnt[s] != '1) begin
                next_st.fcnt[s] = st.fcnt[s] + CW'(1);
            end else if (i_fifo_pop[s] && !i_fifo_push[s] && st.fcnt[s] != '0) begin
                next_st.fcnt[s] = st.fcnt[s] - CW'(1);
            end
            // flush by write, removal or power off; flush beats a push
            // the host asked for an empty fifo, so
            // an entry pushed in that cycle is lost
            if ((hit(i_wr && (i_sock == 1'(s)), i_idx, IDX_FIFO_CTRL) && i_wdata[FC_STATUS])
                || !i_card_in[s] || !i_power_on[s]) begin
                next_st.fcnt[s] = '0;
            end
            next_st.empty[s] = (next_st.fcnt[s] == '0);
            // supply enables, active low
            // the bit only picks which enable goes
            // low; the request itself is i_power_on
            // inpack is honoured only when enabled
            next_st.v5[s] = !(i_power_on[s] && !st.m1[s][M1_SUPPLY_SEL]);
            next_st.v3[s] = !(i_power_on[s] && st.m1[s][M1_SUPPLY_SEL]);
            next_st.inpk[s] = st.m1[s][M1_INPACK_EN] && !i_inpack_n[s];
            if (st.m1[s][M1_SPK_EN]) begin
                spk_x = spk_x ^ i_card_speaker_input[s];
            end
            // any data waiting keeps the clock on
            // in low power mode
            any_busy = any_busy || (st.fcnt[s] != '0);
        end
        // misc two has one chip copy; it takes
        // writes from either socket's index
        // window, i_sock is ignored
        if (hit(i_wr, i_idx, IDX_MISC_TWO)) begin
            next_st.m2 = i_wdata;
        end
        // speaker released only when no socket enables it
        // xor mix: a socket with its enable
        // clear adds nothing to the tone
        next_st.spk    = spk_x;
        next_st.spk_oe = |{st.m1[1][M1_SPK_EN], st.m1[0][M1_SPK_EN]};
        // ring indicate on falling status change, else pass interrupt 15
        // sc_q is last cycle's input; it resets
        // to the idle high level, so a quiet line
        // shows no false fall after reset
        next_st.sc_q = i_card_status_change_input;
        next_st.ri   = st.m2[M2_RING_OUT]
                       ? !(st.sc_q && !i_card_status_change_input)
                       : i_irq15;
        // during a transfer the pci clock runs
        // anyway, so it stays the source then
        next_st.extc   = st.m2[M2_EXT_CLK] && !i_pci_busy;
        // clock runs unless suspended or idle in low power
        // suspend wins; low power lets the clock
        // through while a fifo holds data, the
        // core is busy or pci is busy
        // limitation: the gate is a flop, so it
        // opens one cycle after work appears
        next_st.gate   = !st.m2[M2_SUSPEND]
                         && (!st.m2[M2_LOW_POWER] || any_busy || i_core_busy || i_pci_busy);
        // refusal is a level to the socket
        // cycle logic, held for all of suspend
        next_st.refuse = st.m2[M2_SUSPEND];
        // thresholds only follow the bit; the
        // supply itself is a board choice
        next_st.ttl    = st.m2[M2_CORE_5V];
        // timer tick every cycle or every second cycle
        // tdiv runs free, so turning the divide
        // on may shorten one timer step once
        next_st.tdiv = !st.tdiv;
        next_st.tick = !st.m2[M2_TMR_DIV] || st.tdiv;
        // read mux, status reflects live fifo level
        // data stands only in the cycle after
        // the strobe and is zero otherwise
        // reserved bit 0 is masked on the way out
        next_st.rdata = 8'h00;
        if (i_rd) begin
            case (i_idx)
                IDX_MISC_ONE:  next_st.rdata = st.m1[i_sock] & M1_WRITE_MSK;
                IDX_FIFO_CTRL: next_st.rdata = {st.empty[i_sock], st.fsc[i_sock]};
                IDX_MISC_TWO:  next_st.rdata = st.m2;
                default:       next_st.rdata = 8'h00;
            endcase
        end
    end

    // one register stage for the whole state
    // reset: fifo empty, supplies off, misc
    // two at its low-power default and the
    // ring output at its idle high level
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st       <= '0;
            st.m1    <= {NSOCK{M1_RESET}};
            st.fsc   <= {NSOCK{FC_SCRATCH_RESET}};
            st.m2    <= M2_RESET;
            st.empty <= '1;
            st.v5    <= '1;
            st.v3    <= '1;
            st.sc_q  <= 1'b1;
            st.ri    <= 1'b1;
            st.gate  <= 1'b1;
            st.tick  <= 1'b1;
        end else begin
            // normal run: take the whole next state
            st <= next_st;
        end
    end

    // every output is a plain flop view
    // no output is decoded combinationally,
    // so pads see no glitches
    assign o_rdata                    = st.rdata;
    assign o_vcc5_en_n                = st.v5;
    assign o_vcc3_en_n                = st.v3;
    assign o_fifo_empty               = st.empty;
    assign o_inpack_drv               = st.inpk;
    assign o_speaker_output           = st.spk;
    assign o_speaker_output_oe        = st.spk_oe;
    assign o_interrupt15_ring_out_pin = st.ri;
    assign o_use_ext_clk              = st.extc;
    assign o_clk_gate_en              = st.gate;
    assign o_socket_refuse            = st.refuse;
    assign o_ttl_thresh               = st.ttl;
    assign o_timer_tick               = st.tick;
endmodule : smc_regs
`default_nettype wire

// ### socket_misc_control_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module socket_misc_control_regs_bench;
    import smc_pkg::*;
    localparam int NSOCK = 2;
    logic i_clk, i_rst_n, i_wr, i_rd, i_sock, i_pci_busy, i_pci_clk_ok, i_core_busy, i_irq15, drain;
    logic i_card_status_change_input, i_interrupt14_external_clock_pin, o_speaker_output, o_speaker_output_oe;
    logic o_interrupt15_ring_out_pin, o_use_ext_clk, o_clk_gate_en, o_socket_refuse, o_ttl_thresh, o_timer_tick;
    logic [7:0] i_idx, i_wdata, o_rdata;
    logic [1:0] i_power_on, i_card_in, i_fifo_push, i_fifo_pop, i_card_speaker_input, i_inpack_n, i_mgmt_irq;
    logic [1:0] i_sys_irq, o_vcc5_en_n, o_vcc3_en_n, o_fifo_empty, o_inpack_drv, o_mgmt_pin, o_mgmt_pin_oe;
    logic [1:0] o_system_interrupt_pins, o_system_interrupt_pins_oe;
    int err_total = 0, n_checks = 0, cycles = 0, n;
    smc_regs #(.NSOCK(NSOCK)) i_dut (.*);
    smc_card_model i_card (.i_clk(i_clk), .i_drain(drain), .i_fifo_push(i_fifo_push),
                           .o_fifo_pop(i_fifo_pop), .o_card_speaker_input(i_card_speaker_input));
    always #12.5 i_clk = ~i_clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk);
    endtask : cyc
    // one-cycle strobes, launched at a falling edge
    task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] v);
        @(negedge i_clk);
        {i_sock, i_idx, i_wdata, i_wr} = {s, a, v, 1'b1};
        @(negedge i_clk);
        i_wr = 1'b0;
        cyc(2);
    endtask : wr
    task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        {i_sock, i_idx, i_rd} = {s, a, 1'b1};
        @(negedge i_clk);
        i_rd = 1'b0;
        chk(o_rdata, exp);
    endtask : rd
    task automatic t_regs;
        rd(0, IDX_MISC_ONE, M1_RESET);
        rd(1, IDX_FIFO_CTRL, 8'h80);
        rd(0, IDX_MISC_TWO, M2_RESET);
        rd(0, 8'h20, 8'h00);
        wr(0, IDX_MISC_ONE, 8'hff);
        rd(0, IDX_MISC_ONE, 8'hfe);
        rd(1, IDX_MISC_ONE, 8'h00);
        wr(0, IDX_FIFO_CTRL, 8'h7f);
        rd(0, IDX_FIFO_CTRL, 8'hff);
        wr(0, IDX_MISC_ONE, 8'h00);
    endtask : t_regs
    task automatic t_fifo;
        i_fifo_push = 2'h1;
        cyc(2);
        {i_fifo_push, drain} = 3'h1;
        rd(0, IDX_FIFO_CTRL, 8'h7f);
        n = 0;
        while (o_fifo_empty[0] !== 1'b1 && n < 40) begin
            @(negedge i_clk);
            n++;
        end
        rd(0, IDX_FIFO_CTRL, 8'hff);
        {i_fifo_push, drain} = 3'h2;
        wr(0, IDX_FIFO_CTRL, 8'h7f);
        i_fifo_push = 2'h0;
        rd(0, IDX_FIFO_CTRL, 8'h7f);
        wr(0, IDX_FIFO_CTRL, 8'hff);
        rd(0, IDX_FIFO_CTRL, 8'hff);
        i_fifo_push = 2'h1;
        @(negedge i_clk);
        {i_fifo_push, i_card_in} = 4'h2;
        cyc(3);
        chk(8'(o_fifo_empty[0]), 8'h1);
        i_card_in = 2'h3;
    endtask : t_fifo
    // socket a pin functions; pulse table covers both modes and a dead clock
    task automatic t_sock;
        logic [7:0] md[4] = '{8'h04, 8'h08, 8'h00, 8'h0c};
        logic [1:0] ex[4] = '{2'h2, 2'h1, 2'h0, 2'h0};
        logic [1:0] px[4] = '{2'h1, 2'h2, 2'h3, 2'h0}; // pin levels with request high
        logic [1:0] o;
        logic [1:0] p;
        wr(0, IDX_MISC_ONE, 8'h02);
        chk(8'({o_vcc3_en_n[0], o_vcc5_en_n[0]}), 8'h1);
        wr(0, IDX_MISC_ONE, 8'h90);
        chk(8'({o_vcc3_en_n[0], o_vcc5_en_n[0]}), 8'h2);
        i_inpack_n = 2'h2;
        cyc(2);
        chk(8'({o_speaker_output_oe, o_inpack_drv[0]}), 8'h3);
        {i_mgmt_irq, i_sys_irq} = 4'h5;
        for (int k = 0; k < 4; k++) begin
            {i_pci_clk_ok, i_interrupt14_external_clock_pin} = {2{k != 3}};
            wr(0, IDX_MISC_ONE, md[k]);
            o = 2'h0;
            repeat (20) begin
                p = {o_mgmt_pin_oe[0], o_system_interrupt_pins_oe[0]};
                @(negedge i_clk);
                o |= p ^ {o_mgmt_pin_oe[0], o_system_interrupt_pins_oe[0]};
            end
            chk(8'(o), 8'(ex[k]));
            chk(8'({o_mgmt_pin[0], o_system_interrupt_pins[0]}), 8'(px[k]));
        end
        {i_mgmt_irq, i_sys_irq} = 4'h0;
        chk(8'({o_speaker_output_oe, o_inpack_drv[0]}), 8'h0);
    endtask : t_sock
    task automatic t_chip;
        chk(8'(o_clk_gate_en), 8'h0);
        i_core_busy = 1'b1;
        cyc(2);
        chk(8'(o_clk_gate_en), 8'h1);
        i_core_busy = 1'b0;
        wr(0, IDX_MISC_TWO, 8'h08);
        rd(1, IDX_MISC_TWO, 8'h08);
        chk(8'(o_ttl_thresh), 8'h1);
        wr(0, IDX_MISC_TWO, 8'h05);
        chk(8'({o_socket_refuse, o_clk_gate_en, o_use_ext_clk}), 8'h5);
        i_pci_busy = 1'b1;
        wr(0, IDX_MISC_TWO, 8'h11);
        chk(8'({o_socket_refuse, o_clk_gate_en, o_use_ext_clk}), 8'h2);
        n = 0;
        repeat (8) begin
            @(negedge i_clk);
            n += o_timer_tick;
        end
        chk(8'(n), 8'h4);
        wr(0, IDX_MISC_TWO, 8'h80);
        i_card_status_change_input = 1'b0;
        n = 0;
        repeat (4) begin
            @(negedge i_clk);
            n += !o_interrupt15_ring_out_pin;
        end
        chk(8'(n), 8'h1);
        wr(0, IDX_MISC_TWO, 8'h00);
        chk(8'(o_interrupt15_ring_out_pin), 8'h0);
        i_irq15 = 1'b1;
        cyc(2);
        chk(8'(o_interrupt15_ring_out_pin), 8'h1);
    endtask : t_chip
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end
    initial begin
        {i_clk, i_rst_n, i_wr, i_rd, i_sock, i_pci_busy, i_core_busy, i_irq15, drain} = '0;
        {i_idx, i_wdata, i_fifo_push, i_mgmt_irq, i_sys_irq} = '0;
        {i_pci_clk_ok, i_card_status_change_input, i_interrupt14_external_clock_pin} = '1;
        {i_inpack_n, i_power_on, i_card_in} = '1;
        cyc(4);
        i_rst_n = 1'b1;
        t_regs();
        t_fifo();
        t_sock();
        t_chip();
        results();
    end
endmodule : socket_misc_control_regs_bench
bind smc_regs smc_chk #(.NSOCK(NSOCK)) i_chk (.*);
`default_nettype wire
